// ==== rtl/vlc_pkg.sv ====
// Constants for the vendor link control register bank.
// Assumes one 32-bit register at offset zero of the vendor window.
package vlc_pkg;
    localparam logic [7:0] VLC_OFFSET = 8'h00;
    localparam int BIT_KEEPER = 21;
    localparam int BIT_PM_VIS = 20;
    localparam int BIT_TEST_SRC = 19;
    localparam int BIT_EE_FAST = 18;
    localparam int BIT_MODE_LO = 16;
    localparam int BIT_PROG_MIR = 14;
    localparam int BIT_ENH_MIR = 13;
    localparam int BIT_SPD_LOCK = 12;
    localparam int BIT_DET_OFF = 11;
    localparam int BIT_FORCE_ABS = 10;
    localparam int BIT_ALT_CONCAT = 9;
    localparam int BIT_ALT_ACCEL = 7;
    localparam int BIT_ALT_MIXED = 6;
    localparam int BIT_ALT_IDLE = 5;
    // Writable bits 21:16, 14:9, 7:5; low nibble lives elsewhere
    localparam logic [31:0] VLC_WMASK = 32'h003f_7ee0;
    localparam logic [31:0] VLC_RESET = 32'h0000_0000;
    localparam logic [1:0] MODE_XOR0 = 2'h0;
    localparam logic [1:0] MODE_AND = 2'h1;
    localparam logic [1:0] MODE_OR = 2'h2;
    localparam logic [1:0] MODE_XOR3 = 2'h3;
    localparam logic [7:0] LOST_LIMIT = 8'hff;
    localparam int SPD_W = 3;
endpackage

// ==== rtl/feature_combine.sv ====
// Combines the enhanced-PHY enable with one alternate bit.
// Assumes mode and inputs are registered by the caller.
`timescale 1ns/1ns
module feature_combine
    import vlc_pkg::*;
(
    input wire logic [1:0] mode_i,
    input wire logic enh_i,
    input wire logic alt_i,
    output logic eff_o
);
    // Mode selects the combining operator
    always_comb begin
        unique case (mode_i)
            MODE_AND: eff_o = enh_i & alt_i;
            MODE_OR: eff_o = enh_i | alt_i;
            MODE_XOR0, MODE_XOR3: eff_o = enh_i ^ alt_i;
        endcase
    end
endmodule // feature_combine

// ==== rtl/master_detect.sv ====
// Counts consecutive lost cycles to decide a cycle master is absent.
// Assumes one-cycle event pulses on the register clock.
`timescale 1ns/1ns
module master_detect
    import vlc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic cycle_lost_i,
    input wire logic cycle_ok_i,
    input wire logic det_off_i,
    input wire logic force_i,
    output logic absent_o
);
    logic [7:0] lost_cnt_q;
    logic seen_q;

    // Saturating run length; any good cycle restarts it
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lost_cnt_q <= 8'h00;
        end else if (cycle_ok_i || det_off_i) begin
            lost_cnt_q <= 8'h00;
        end else if (cycle_lost_i && lost_cnt_q != LOST_LIMIT) begin
            lost_cnt_q <= lost_cnt_q + 8'h01;
        end
    end

    // Detector verdict, held until a good cycle or until the detector is disabled
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= !det_off_i && !cycle_ok_i && lost_cnt_q == LOST_LIMIT;
        end
    end

    // Forcing overrides detector and its disable
    assign absent_o = force_i | seen_q;
endmodule // master_detect

// ==== rtl/vendor_link_control.sv ====
// Vendor link control register with mirrored host-control bits.
// Assumes PCI-clock register port strobes and one-cycle link event pulses.
// Assumes host-control and bus-options writes arrive as single-cycle pulses.
// Low nibble of the word is kept by another block and reads zero here.
`timescale 1ns/1ns

module vendor_link_control
    import vlc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    // Host control register side
    input wire logic hc_wr_i,
    input wire logic hc_prog_i,
    input wire logic hc_enh_i,
    output logic phy_program_allow_o,
    output logic phy_enh_allow_o,
    // Bus options link speed field
    input wire logic spd_wr_i,
    input wire logic [2:0] spd_wdata_i,
    output logic [2:0] link_speed_o,
    // Link cycle events
    input wire logic cycle_lost_i,
    input wire logic cycle_ok_i,
    output logic master_absent_o,
    // Test sources
    input wire logic nand_tree_i,
    input wire logic bist_status_i,
    output logic test_output_pin_o,
    // Feature controls
    output logic bus_keeper_on_o,
    output logic pm_struct_visible_o,
    output logic eeprom_fast_timing_o,
    output logic eff_concat_o,
    output logic eff_accel_o,
    output logic eff_mixed_o,
    output logic eff_idle_o,
    output logic hs_keeps_medium_o
);
    // Stored word and its next value
    logic [31:0] ctl_q;
    logic [31:0] ctl_d;

    // Mirror and speed flops, and the speed write enable
    logic prog_q;
    logic enh_q;
    logic [2:0] spd_q;
    logic spd_take;

    // Decode results
    logic vlc_sel;
    logic vlc_wr;
    logic vlc_rd;
    logic [1:0] mode;

    // Combiner, detector, test select and read results
    logic concat_c;
    logic accel_c;
    logic mixed_c;
    logic idle_c;
    logic absent_c;
    logic test_src_c;
    logic [31:0] rd_word_c;

    // Mirror bits live in their own flops so a host write leaves no stale copy
    localparam logic [31:0] MIRROR_MASK = (32'h1 << BIT_PROG_MIR) | (32'h1 << BIT_ENH_MIR);

    // Stored part of a port write; reserved and mirror bits are dropped
    function automatic logic [31:0] merge_write(logic [31:0] wdata);
        return wdata & VLC_WMASK & ~MIRROR_MASK;
    endfunction

    // Read word: stored fields plus the live mirror flops
    function automatic logic [31:0] read_word(logic [31:0] ctl, logic prog, logic enh);
        logic [31:0] word;
        word = ctl & VLC_WMASK;
        word[BIT_PROG_MIR] = prog;
        word[BIT_ENH_MIR] = enh;
        return word;
    endfunction

    // Test pin source select
    function automatic logic pick_test(logic sel, logic nand_src, logic bist_src);
        return sel ? bist_src : nand_src;
    endfunction

    // Address decode; only one word is mapped here
    assign vlc_sel = reg_addr_i == VLC_OFFSET;
    assign vlc_wr = reg_wr_i && vlc_sel;
    assign vlc_rd = reg_rd_i && vlc_sel;
    assign mode = ctl_q[BIT_MODE_LO +: 2];
    assign test_src_c = pick_test(ctl_q[BIT_TEST_SRC], nand_tree_i, bist_status_i);

    // Read word assembled ahead of the strobe
    assign rd_word_c = read_word(ctl_q, prog_q, enh_q);

    // Speed write accepted only while unlocked; the lock bit stays writable
    assign spd_take = spd_wr_i && !ctl_q[BIT_SPD_LOCK];

    // Masked write keeps reserved bits zero
    always_comb begin
        ctl_d = ctl_q;
        if (vlc_wr) begin
            ctl_d = merge_write(reg_wdata_i);
        end
    end

    // Control word; mirror bits kept separately below
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl_q <= VLC_RESET;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // Program mirror: port write wins over a host write in the same cycle
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prog_q <= 1'b0;
        end else if (vlc_wr) begin
            prog_q <= reg_wdata_i[BIT_PROG_MIR];
        end else if (hc_wr_i) begin
            prog_q <= hc_prog_i;
        end
    end

    // Enhanced mirror: same priority as the program mirror
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enh_q <= 1'b0;
        end else if (vlc_wr) begin
            enh_q <= reg_wdata_i[BIT_ENH_MIR];
        end else if (hc_wr_i) begin
            enh_q <= hc_enh_i;
        end
    end

    // Link speed field, frozen while locked
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spd_q <= '0;
        end else if (spd_take) begin
            spd_q <= spd_wdata_i;
        end
    end

    // One combiner per alternate feature bit
    feature_combine u_concat (
        .mode_i(mode),
        .enh_i(enh_q),
        .alt_i(ctl_q[BIT_ALT_CONCAT]),
        .eff_o(concat_c)
    );

    // Acknowledge-accelerated arbitration
    feature_combine u_accel (
        .mode_i(mode),
        .enh_i(enh_q),
        .alt_i(ctl_q[BIT_ALT_ACCEL]),
        .eff_o(accel_c)
    );

    // Mixed-speed concatenation
    feature_combine u_mixed (
        .mode_i(mode),
        .enh_i(enh_q),
        .alt_i(ctl_q[BIT_ALT_MIXED]),
        .eff_o(mixed_c)
    );

    // Idle signalling after grant
    feature_combine u_idle (
        .mode_i(mode),
        .enh_i(enh_q),
        .alt_i(ctl_q[BIT_ALT_IDLE]),
        .eff_o(idle_c)
    );

    // Cycle master detector
    master_detect u_detect (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .cycle_lost_i(cycle_lost_i),
        .cycle_ok_i(cycle_ok_i),
        .det_off_i(ctl_q[BIT_DET_OFF]),
        .force_i(ctl_q[BIT_FORCE_ABS]),
        .absent_o(absent_c)
    );

    // Bus keeper enable, one cycle behind the control word
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_keeper_on_o <= 1'b0;
        end else begin
            bus_keeper_on_o <= ctl_q[BIT_KEEPER];
        end
    end

    // Power-management structure visibility
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pm_struct_visible_o <= 1'b0;
        end else begin
            pm_struct_visible_o <= ctl_q[BIT_PM_VIS];
        end
    end

    // EEPROM timing select
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eeprom_fast_timing_o <= 1'b0;
        end else begin
            eeprom_fast_timing_o <= ctl_q[BIT_EE_FAST];
        end
    end

    // Test pin; sources are sampled, so the pin lags them by a cycle
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            test_output_pin_o <= 1'b0;
        end else begin
            test_output_pin_o <= test_src_c;
        end
    end

    // Handshake concatenation enable
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eff_concat_o <= 1'b0;
        end else begin
            eff_concat_o <= concat_c;
        end
    end

    // Accelerated arbitration enable
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eff_accel_o <= 1'b0;
        end else begin
            eff_accel_o <= accel_c;
        end
    end

    // Mixed-speed concatenation enable
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eff_mixed_o <= 1'b0;
        end else begin
            eff_mixed_o <= mixed_c;
        end
    end

    // Idle signalling enable
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eff_idle_o <= 1'b0;
        end else begin
            eff_idle_o <= idle_c;
        end
    end

    // Medium kept on handshake whenever acceleration is effective
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hs_keeps_medium_o <= 1'b0;
        end else begin
            hs_keeps_medium_o <= accel_c;
        end
    end

    // Master absence, forced or detected
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            master_absent_o <= 1'b0;
        end else begin
            master_absent_o <= absent_c;
        end
    end

    // Program mirror towards the host control side
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phy_program_allow_o <= 1'b0;
        end else begin
            phy_program_allow_o <= prog_q;
        end
    end

    // Enhanced mirror towards the host control side
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phy_enh_allow_o <= 1'b0;
        end else begin
            phy_enh_allow_o <= enh_q;
        end
    end

    // Link speed field
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_speed_o <= '0;
        end else begin
            link_speed_o <= spd_q;
        end
    end

    // Read data; mirrors read live, unmapped reads zero
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= '0;
        end else if (vlc_rd) begin
            reg_rdata_o <= rd_word_c;
        end else begin
            reg_rdata_o <= '0;
        end
    end
endmodule // vendor_link_control

// ==== testbench/vlc_asserts.sv ====
// Port checker for the vendor link control bank.
// Assumes one clock domain and the bank's async active-low reset.
`timescale 1ns/1ns
module vlc_asserts
    import vlc_pkg::*;
(
    // Clock, reset, register port and speed write strobe
    input wire logic mclk_i, rst_b_i, reg_wr_i, reg_rd_i, spd_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o,
    // Watched outputs
    input wire logic [2:0] link_speed_o,
    input wire logic phy_enh_allow_o, bus_keeper_on_o, pm_struct_visible_o,
    input wire logic eff_concat_o, eff_accel_o, hs_keeps_medium_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // Mapped register write, seen two edges before derived outputs move
    sequence wr_s;
        reg_wr_i && reg_addr_i == VLC_OFFSET;
    endsequence
    // Expected feature enable; own copy, not the design's
    function automatic logic comb(logic [1:0] m, logic e, logic a);
        return (m == MODE_AND) ? (e & a) : (m == MODE_OR) ? (e | a) : (e ^ a);
    endfunction
    chk_keeper_bit: assert property (wr_s |-> ##2
        bus_keeper_on_o == $past(reg_wdata_i[BIT_KEEPER], 2)) else $error("keeper bit");
    chk_pm_bit: assert property (wr_s |-> ##2
        pm_struct_visible_o == $past(reg_wdata_i[BIT_PM_VIS], 2)) else $error("pm bit");
    chk_enh_mirror: assert property (wr_s |-> ##2
        phy_enh_allow_o == $past(reg_wdata_i[BIT_ENH_MIR], 2)) else $error("enh mirror");
    chk_concat_mix: assert property (wr_s |-> ##2 eff_concat_o == comb(
        $past(reg_wdata_i[17:16], 2), $past(reg_wdata_i[BIT_ENH_MIR], 2),
        $past(reg_wdata_i[BIT_ALT_CONCAT], 2))) else $error("concat enable");
    chk_accel_medium: assert property (hs_keeps_medium_o == eff_accel_o)
        else $error("medium hold");
    chk_rsvd_zero: assert property (reg_rd_i |=> (reg_rdata_o & ~VLC_WMASK) == 32'h0)
        else $error("reserved bits");
    chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i != VLC_OFFSET
        |=> reg_rdata_o == 32'h0) else $error("unmapped read");
    chk_speed_cause: assert property ($changed(link_speed_o) |-> $past(spd_wr_i, 2))
        else $error("speed change");
endmodule // vlc_asserts
bind vendor_link_control vlc_asserts chk (.*);

// ==== testbench/tb_top.sv ====
// Directed bench for the vendor link control bank.
// Assumes the bank alone, driven on rising edges at 100 MHz.
`timescale 1ns/1ns
module tb_top;
    import vlc_pkg::*;
    logic mclk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, hc_wr_i = 0, hc_prog_i = 0;
    logic hc_enh_i = 0, spd_wr_i = 0, cycle_lost_i = 0, cycle_ok_i = 0, nand_tree_i = 0;
    logic bist_status_i = 0, keep, pm, fast, prog, enh, absent, tpin, cc, ac, mx, idl, hs;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [2:0] spd_wdata_i = 3'h0, link_speed_o;
    int bad_count = 0, check_count = 0;
    always #5 mclk_i = ~mclk_i;
    vendor_link_control uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .hc_wr_i(hc_wr_i), .hc_prog_i(hc_prog_i), .hc_enh_i(hc_enh_i),
        .phy_program_allow_o(prog), .phy_enh_allow_o(enh), .spd_wr_i(spd_wr_i),
        .spd_wdata_i(spd_wdata_i), .link_speed_o(link_speed_o), .cycle_lost_i(cycle_lost_i),
        .cycle_ok_i(cycle_ok_i), .master_absent_o(absent), .nand_tree_i(nand_tree_i),
        .bist_status_i(bist_status_i), .test_output_pin_o(tpin), .bus_keeper_on_o(keep),
        .pm_struct_visible_o(pm), .eeprom_fast_timing_o(fast), .eff_concat_o(cc),
        .eff_accel_o(ac), .eff_mixed_o(mx), .eff_idle_o(idl), .hs_keeps_medium_o(hs));
    // Verdict and end of run, shared with the watchdog
    task results();
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // Let derived outputs settle, two flop stages plus margin
    task settle();
        repeat (3) @(posedge mclk_i);
        #1;
    endtask
    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge mclk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        settle();
    endtask
    // Read data stands for one cycle only, so sample right after the read edge
    task rd(logic [7:0] a, logic [31:0] e);
        @(posedge mclk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata_o);
    endtask
    task ev(int n, logic lost);
        repeat (n) begin
            @(posedge mclk_i);
            {cycle_lost_i, cycle_ok_i} <= {lost, !lost};
            @(posedge mclk_i);
            {cycle_lost_i, cycle_ok_i} <= 2'h0;
        end
        settle();
    endtask
    task spd(logic [2:0] v);
        @(posedge mclk_i);
        {spd_wdata_i, spd_wr_i} <= {v, 1'b1};
        @(posedge mclk_i);
        spd_wr_i <= 1'b0;
        settle();
    endtask
    // Watchdog sized well past the roughly 1600 cycles of the sequence
    initial begin
        repeat (8000) @(posedge mclk_i);
        bad_count++;
        results();
    end
    initial begin
        logic [1:0] m;
        logic e, a, x;
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rd(8'h00, 32'h0);
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00, VLC_WMASK);
        chk("keep_pm_fast", 32'h7, {keep, pm, fast});
        chk("absent", 32'h1, absent);
        {nand_tree_i, bist_status_i} <= 2'h1;
        settle();
        chk("tpin_bist", 32'h1, tpin);
        wr(8'h04, 32'h0);
        rd(8'h00, VLC_WMASK);
        rd(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        chk("keep_pm_fast", 32'h0, {keep, pm, fast, tpin});
        chk("absent", 32'h0, absent);
        {nand_tree_i, bist_status_i} <= 2'h2;
        settle();
        chk("tpin_nand", 32'h1, tpin);
        // Every mode with every enable and alternate pairing
        for (int i = 0; i < 16; i++) begin
            {m, e, a} = i[3:0];
            x = (m == MODE_AND) ? (e & a) : (m == MODE_OR) ? (e | a) : (e ^ a);
            wr(8'h00, {14'h0, m, 2'h0, e, 3'h0, a, 1'b0, a, a, a, 5'h0});
            chk("eff", {27'h0, {5{x}}}, {cc, ac, mx, idl, hs});
        end
        wr(8'h00, 32'h0);
        spd(3'h5);
        chk("speed", 32'h5, link_speed_o);
        wr(8'h00, 32'h1000);
        spd(3'h2);
        chk("speed_locked", 32'h5, link_speed_o);
        @(posedge mclk_i);
        {hc_wr_i, hc_prog_i, hc_enh_i} <= 3'h6;
        @(posedge mclk_i);
        hc_wr_i <= 1'b0;
        settle();
        rd(8'h00, 32'h5000);
        wr(8'h00, 32'h2000);
        chk("mirrors", 32'h1, {prog, enh});
        wr(8'h00, 32'h6000);
        @(posedge mclk_i);
        {hc_wr_i, hc_prog_i, hc_enh_i} <= 3'h4;
        @(posedge mclk_i);
        hc_wr_i <= 1'b0;
        settle();
        rd(8'h00, 32'h0);
        chk("mirrors_host", 32'h0, {prog, enh});
        wr(8'h00, 32'h0);
        ev(200, 1'b1);
        ev(1, 1'b0);
        ev(254, 1'b1);
        chk("absent_254", 32'h0, absent);
        ev(1, 1'b1);
        chk("absent_255", 32'h1, absent);
        wr(8'h00, 32'h800);
        ev(255, 1'b1);
        chk("absent_off", 32'h0, absent);
        wr(8'h00, 32'hc00);
        chk("absent_forced", 32'h1, absent);
        results();
    end
endmodule // tb_top
